//--- verilog/rpec_pkg.sv
// Contract
// - The output voltage code is six bits wide, and the voltage is 0.55 V plus the code times a 10 mV step.
// - The pin select mask has eight bits, bit n belongs to pin n, and a 1 lets that pin enable the regulator.
// - The pin select mask takes effect only while the sequence field is 111 and the enable field is 10.
// - With several pins selected, the regulator is on while any selected pin is high.
// - The first alternate voltage code applies while the controlling pins read 00, with the same encoding; the code applies it only while scale_cfg is nonzero.
package rpec_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_OUT_VCODE   = 6'h1F;
    localparam logic [5:0] IDX_PIN_MASK    = 6'h20;
    localparam logic [5:0] IDX_SCALE_CFG   = 6'h21;
    localparam logic [5:0] IDX_ALT_VZERO   = 6'h22;
    localparam logic [5:0] IDX_ENABLE_CTRL = 6'h30;
    localparam logic [5:0] IDX_STATUS      = 6'h31;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////
    // Field positions inside the enable control and status registers
    localparam int SEQ_LSB = 5;
    localparam int SEQ_MSB = 7;
    localparam int EN_LSB  = 0;
    localparam int EN_MSB  = 1;
    localparam int STAT_ON = 7;

    // Mode codes
    localparam logic [2:0] SEQ_PIN_MODE = 3'h7;
    localparam logic [1:0] EN_PIN_MODE  = 2'h2;
    localparam logic [1:0] EN_FORCE_ON  = 2'h1;
    localparam logic [1:0] DVS_PINS_ZERO = 2'h0;

    // Voltage encoding in millivolts
    localparam int V_BASE_MV = 550;
    localparam int V_STEP_MV = 10;
    localparam int MV_W      = 11;

    // Reset values
    localparam logic [7:0] RST_MASK  = 8'h00;
    localparam logic [5:0] RST_VCODE = 6'h00;
    localparam logic [4:0] RST_CFG   = 5'h00;
    localparam logic [2:0] RST_SEQ   = 3'h0;
    localparam logic [1:0] RST_EN    = 2'h0;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] pin_mask;
        logic [4:0] scale_cfg;
        logic [5:0] alt_vzero;
        logic [5:0] out_vcode;
        logic [2:0] seq_field;
        logic [1:0] en_field;
    } rpec_regs_t;

    localparam rpec_regs_t RST_REGS = '{RST_MASK, RST_CFG, RST_VCODE,
                                        RST_VCODE, RST_SEQ, RST_EN};

endpackage

//--- verilog/rpec_pin_sync.sv
`timescale 1ns/1ps
module rpec_pin_sync (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] pin_async,
    output logic      [7:0] pin_sync
);
    logic [7:0] stage1;
    logic [7:0] next_stage1;
    logic [7:0] next_pin_sync;

    ////////////////////////////////////////////////////////////////////////
    // Two flops per pin; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            always_comb begin
                next_stage1[i]   = pin_async[i];
                next_pin_sync[i] = stage1[i];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1   <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            stage1   <= next_stage1;
            pin_sync <= next_pin_sync;
        end
    end
endmodule

//--- verilog/rpec_top.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module rpec_top (
    input  wire logic                          clk,
    input  wire logic                          rst,
    // AXI4-Lite write address
    input  wire logic [rpec_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [rpec_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [rpec_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    // AXI4-Lite read data
    output logic [rpec_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Multi-purpose pins, asynchronous
    input  wire logic [7:0]                    multipurpose_pin,
    // Regulator controls
    output logic                               regulator_on,
    output logic [5:0]                         active_voltage_code,
    output logic [rpec_pkg::MV_W-1:0]          active_voltage_mv
);

    ////////////////////////////////////////////////////////////////////////
    // State
    rpec_pkg::rpec_regs_t            regs;
    rpec_pkg::rpec_regs_t            next_regs;
    logic                            aw_held;
    logic                            next_aw_held;
    logic [5:0]                      aw_idx;
    logic [5:0]                      next_aw_idx;
    logic                            w_held;
    logic                            next_w_held;
    logic [7:0]                      w_byte;
    logic [7:0]                      next_w_byte;
    logic                            w_lane0;
    logic                            next_w_lane0;
    logic                            next_awready;
    logic                            next_wready;
    logic                            next_bvalid;
    logic [1:0]                      next_bresp;
    logic                            next_arready;
    logic                            next_rvalid;
    logic [1:0]                      next_rresp;
    logic [rpec_pkg::DATA_W-1:0]     next_rdata;
    logic                            next_on;
    logic [5:0]                      next_code;
    logic [rpec_pkg::MV_W-1:0]       next_mv;
    logic [7:0]                      pins;
    logic [7:0]                      rd_byte;
    logic                            rd_hit;
    logic                            pin_mode;

    // Pins cross into the clock domain before any logic reads them
    rpec_pin_sync u_sync (
        .clk       (clk),
        .rst       (rst),
        .pin_async (multipurpose_pin),
        .pin_sync  (pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read decode; unused bits come back as zero
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (s_axi_araddr[rpec_pkg::ADDR_W-1:2])
            rpec_pkg::IDX_OUT_VCODE:
                rd_byte = {2'h0, regs.out_vcode};
            rpec_pkg::IDX_PIN_MASK:
                rd_byte = regs.pin_mask;
            rpec_pkg::IDX_SCALE_CFG:
                rd_byte = {3'h0, regs.scale_cfg};
            rpec_pkg::IDX_ALT_VZERO:
                rd_byte = {2'h0, regs.alt_vzero};
            rpec_pkg::IDX_ENABLE_CTRL: begin
                rd_byte[rpec_pkg::SEQ_MSB:rpec_pkg::SEQ_LSB] = regs.seq_field;
                rd_byte[rpec_pkg::EN_MSB:rpec_pkg::EN_LSB]   = regs.en_field;
            end
            rpec_pkg::IDX_STATUS: begin
                rd_byte[5:0]              = active_voltage_code;
                rd_byte[rpec_pkg::STAT_ON] = regulator_on;
            end
            default:
                rd_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus channels and register writes
    always_comb begin
        next_regs    = regs;
        next_aw_held = aw_held;
        next_aw_idx  = aw_idx;
        next_w_held  = w_held;
        next_w_byte  = w_byte;
        next_w_lane0 = w_lane0;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rresp   = s_axi_rresp;
        next_rdata   = s_axi_rdata;
        // Address and data are caught independently, in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_idx  = s_axi_awaddr[rpec_pkg::ADDR_W-1:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held  = 1'b1;
            next_w_byte  = s_axi_wdata[7:0];
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Commit once both halves are held and no answer is pending
        if (next_aw_held && next_w_held && !next_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = rpec_pkg::RESP_OKAY;
            unique case (next_aw_idx)
                rpec_pkg::IDX_OUT_VCODE:
                    if (next_w_lane0) begin
                        next_regs.out_vcode = next_w_byte[5:0];
                    end
                rpec_pkg::IDX_PIN_MASK:
                    if (next_w_lane0) begin
                        next_regs.pin_mask = next_w_byte;
                    end
                rpec_pkg::IDX_SCALE_CFG:
                    if (next_w_lane0) begin
                        next_regs.scale_cfg = next_w_byte[4:0];
                    end
                rpec_pkg::IDX_ALT_VZERO:
                    if (next_w_lane0) begin
                        next_regs.alt_vzero = next_w_byte[5:0];
                    end
                rpec_pkg::IDX_ENABLE_CTRL:
                    if (next_w_lane0) begin
                        next_regs.seq_field =
                            next_w_byte[rpec_pkg::SEQ_MSB:rpec_pkg::SEQ_LSB];
                        next_regs.en_field =
                            next_w_byte[rpec_pkg::EN_MSB:rpec_pkg::EN_LSB];
                    end
                rpec_pkg::IDX_STATUS: ;  // Read-only, write dropped
                default:
                    next_bresp = rpec_pkg::RESP_SLVERR;
            endcase
        end
        // Reads answer one cycle after the address is taken
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = {24'h000000, rd_byte};
            next_rresp  = rd_hit ? rpec_pkg::RESP_OKAY
                                 : rpec_pkg::RESP_SLVERR;
        end
        // One transfer per direction in flight keeps the slave simple
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // Regulator enable and voltage selection
    always_comb begin
        pin_mode = (regs.seq_field == rpec_pkg::SEQ_PIN_MODE) &&
                   (regs.en_field == rpec_pkg::EN_PIN_MODE);
        if (pin_mode) begin
            next_on = |(regs.pin_mask & pins);
        end else begin
            // Mask is ignored outside the pin mode
            next_on = (regs.en_field == rpec_pkg::EN_FORCE_ON);
        end
        // Scaling is live when its config is nonzero; pins 1:0 steer it
        if ((regs.scale_cfg != rpec_pkg::RST_CFG) &&
            (pins[1:0] == rpec_pkg::DVS_PINS_ZERO)) begin
            next_code = regs.alt_vzero;
        end else begin
            next_code = regs.out_vcode;
        end
        next_mv = rpec_pkg::MV_W'(int'(next_code) * rpec_pkg::V_STEP_MV
                                  + rpec_pkg::V_BASE_MV);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            regs                <= rpec_pkg::RST_REGS;
            aw_held             <= 1'b0;
            aw_idx              <= 6'h00;
            w_held              <= 1'b0;
            w_byte              <= 8'h00;
            w_lane0             <= 1'b0;
            s_axi_awready       <= 1'b0;
            s_axi_wready        <= 1'b0;
            s_axi_bvalid        <= 1'b0;
            s_axi_bresp         <= rpec_pkg::RESP_OKAY;
            s_axi_arready       <= 1'b0;
            s_axi_rvalid        <= 1'b0;
            s_axi_rresp         <= rpec_pkg::RESP_OKAY;
            s_axi_rdata         <= 32'h00000000;
            regulator_on        <= 1'b0;
            active_voltage_code <= rpec_pkg::RST_VCODE;
            active_voltage_mv   <= rpec_pkg::MV_W'(rpec_pkg::V_BASE_MV);
        end else begin
            regs                <= next_regs;
            aw_held             <= next_aw_held;
            aw_idx              <= next_aw_idx;
            w_held              <= next_w_held;
            w_byte              <= next_w_byte;
            w_lane0             <= next_w_lane0;
            s_axi_awready       <= next_awready;
            s_axi_wready        <= next_wready;
            s_axi_bvalid        <= next_bvalid;
            s_axi_bresp         <= next_bresp;
            s_axi_arready       <= next_arready;
            s_axi_rvalid        <= next_rvalid;
            s_axi_rresp         <= next_rresp;
            s_axi_rdata         <= next_rdata;
            regulator_on        <= next_on;
            active_voltage_code <= next_code;
            active_voltage_mv   <= next_mv;
        end
    end
endmodule

//--- tb/rpec_assertions.sv
`timescale 1ns/1ps
module rpec_checker (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_rvalid,
    input wire logic [rpec_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [7:0]                  multipurpose_pin,
    input wire logic                        regulator_on,
    input wire logic [5:0]                  active_voltage_code,
    input wire logic [rpec_pkg::MV_W-1:0]   active_voltage_mv
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Voltage ladder: 550 mV base, 10 mV per code step
    chk_mv_linear: assert property (
        active_voltage_mv == 11'h226 + 11'(active_voltage_code) * 11'h00A)
        else $error("voltage output off the linear ladder");
    chk_mv_ceiling: assert property (
        active_voltage_mv <= 11'h49C)
        else $error("voltage output above the top code");
    // Unused read bits must come back as zero
    chk_rdata_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data carries bits above the register");
    // Outputs move only after a register write or a pin change three
    // edges back; one cycle of slack allows for the synchroniser
    chk_on_cause: assert property (
        $changed(regulator_on) |-> $past(s_axi_bvalid) ||
            $past(multipurpose_pin, 2) != $past(multipurpose_pin, 3) ||
            $past(multipurpose_pin, 3) != $past(multipurpose_pin, 4))
        else $error("regulator enable moved without a cause");
    chk_code_cause: assert property (
        $changed(active_voltage_code) |-> $past(s_axi_bvalid) ||
            $past(multipurpose_pin, 2) != $past(multipurpose_pin, 3) ||
            $past(multipurpose_pin, 3) != $past(multipurpose_pin, 4))
        else $error("active code moved without a cause");
    // An OR of idle pins can never switch the regulator on
    chk_on_needs_pin: assert property (
        $rose(regulator_on) && !$past(s_axi_bvalid) |->
            $past(multipurpose_pin, 3) != 8'h00)
        else $error("regulator switched on with all pins low");
endmodule

bind rpec_top rpec_checker i_rpec_checker (
    .clk, .rst, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata,
    .multipurpose_pin, .regulator_on, .active_voltage_code,
    .active_voltage_mv);

//--- tb/rpec_pin_drv.sv
`timescale 1ns/1ps
module rpec_pin_drv (
    input  wire logic       clk,
    input  wire logic [7:0] want,
    output logic      [7:0] pin
);
    // Board logic moves pin levels just after an edge and holds them
    initial pin = 8'h00;
    always @(posedge clk) begin
        pin <= want;
    end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    miscompares++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [7:0]  want = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, on;
    logic [1:0]  bresp, rresp, bs, rs;
    logic [31:0] rdata, rd;
    logic [7:0]  pin;
    logic [5:0]  code;
    logic [10:0] mv;
    int          n_tests = 0;
    int          miscompares = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    rpec_top i_rpec_top (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .multipurpose_pin(pin),
        .regulator_on(on), .active_voltage_code(code),
        .active_voltage_mv(mv));
    rpec_pin_drv i_rpec_pin_drv (.clk(clk), .want(want), .pin(pin));

    ////////////////////////////////////////////////////////////////////////
    // Bus cycles; each starts on a fresh edge so no signal is set twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s = 4'h1);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // Pins need four edges through driver, synchroniser and output flop; five leave margin
    task automatic pins(input logic [7:0] v);
        want <= v;
        repeat (5) @(posedge clk);
    endtask
    function automatic logic [10:0] mvx(input int c);
        return 11'(rpec_pkg::V_BASE_MV + c * rpec_pkg::V_STEP_MV);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] al [4] = '{8'h7C, 8'h80, 8'h84, 8'h88};
        `CHK("mv_rst", mvx(0), mv)
        for (int i = 0; i < 4; i++) begin
            rdr(al[i]);
            `CHK("reg_rst", 32'h00000000, rd)
        end
    endtask
    task automatic t_vcode;
        wr(8'h7C, 8'hFF);
        rdr(8'h7C);
        `CHK("vcode_rd", 32'h0000003F, rd)
        `CHK("code_top", 6'h3F, code)
        `CHK("mv_top", mvx(63), mv)
        wr(8'h7C, 8'h00);
        rdr(8'h84);
        `CHK("mv_bottom", mvx(0), mv)
    endtask
    task automatic t_regs;
        wr(8'h80, 8'hA5);
        `CHK("bresp_ok", rpec_pkg::RESP_OKAY, bs)
        rdr(8'h80);
        `CHK("mask_rd", 32'h000000A5, rd)
        `CHK("rresp_ok", rpec_pkg::RESP_OKAY, rs)
        wr(8'h84, 8'hFF);
        rdr(8'h84);
        `CHK("cfg_rd", 32'h0000001F, rd)
        wr(8'h88, 8'hFF);
        rdr(8'h88);
        `CHK("alt_rd", 32'h0000003F, rd)
        wr(8'h84, 8'h00);
    endtask
    // Pin mode, one pin at a time then two pin patterns, against a mask of pins 0 and 7
    task automatic t_pins;
        wr(8'hC0, 8'hE2);
        wr(8'h80, 8'h81);
        for (int i = 0; i < 8; i++) begin
            pins(8'h01 << i);
            `CHK("on_pin", (i == 0 || i == 7), on)
        end
        pins(8'h81);
        `CHK("on_or", 1'b1, on)
        pins(8'h7E);
        `CHK("on_excl", 1'b0, on)
    endtask
    // Only sequence 111 with enable 10 lets the mask act
    task automatic t_gate;
        logic [7:0] ctl [5] = '{8'hE2, 8'hC2, 8'hE3, 8'hE1, 8'h62};
        logic [4:0] onx = 5'h09;
        wr(8'h80, 8'hFF);
        pins(8'hFF);
        for (int i = 0; i < 5; i++) begin
            wr(8'hC0, ctl[i]);
            repeat (2) @(posedge clk);
            `CHK("on_mode", onx[i], on)
        end
    endtask
    task automatic t_alt;
        wr(8'h88, 8'h2A);
        wr(8'h7C, 8'h15);
        wr(8'h84, 8'h01);
        pins(8'h00);
        `CHK("alt_code", 6'h2A, code)
        `CHK("alt_mv", mvx(42), mv)
        pins(8'h01);
        `CHK("main_code", 6'h15, code)
        wr(8'h84, 8'h00);
    endtask
    // Control readback, status word, read-only status, dropped lane
    task automatic t_status;
        rdr(8'hC0);
        `CHK("ctl_rd", 32'h00000062, rd)
        wr(8'hC0, 8'h01);
        rdr(8'hC4);
        `CHK("stat_rd", 32'h00000095, rd)
        wr(8'hC4, 8'hFF);
        `CHK("stat_wr_ok", rpec_pkg::RESP_OKAY, bs)
        rdr(8'hC4);
        `CHK("stat_keep", 32'h00000095, rd)
        wr(8'h7C, 8'h3F, 4'h0);
        `CHK("lane_ok", rpec_pkg::RESP_OKAY, bs)
        rdr(8'h7C);
        `CHK("lane_drop", 32'h00000015, rd)
        `CHK("lane_rresp", rpec_pkg::RESP_OKAY, rs)
        `CHK("lane_code", 6'h15, code)
    endtask
    task automatic t_unmapped;
        wr(8'h00, 8'h55);
        `CHK("bresp_bad", rpec_pkg::RESP_SLVERR, bs)
        rdr(8'hFC);
        `CHK("rresp_bad", rpec_pkg::RESP_SLVERR, rs)
        `CHK("rdata_bad", 32'h00000000, rd)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence after 16 cycles of reset
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_vcode;
        t_regs;
        t_pins;
        t_gate;
        t_alt;
        t_status;
        t_unmapped;
        finish_test;
    end
    // Watchdog: the run needs well under a thousand cycles
    initial begin
        #2000000;
        miscompares++;
        finish_test;
    end
endmodule
